// File: src/iep_map.svh
// Register offsets, field positions, reset values and codes for the interrupt enable block
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH

// Special-function register addresses seen by the core
`define IEP_OFS_EN_LOW 12'h03A
`define IEP_OFS_EN_HIGH 12'h03B
`define IEP_OFS_EN_EXT 12'h03C
`define IEP_OFS_EN_TOP 12'h03D
`define IEP_OFS_LAT_LOW 12'hFE0
`define IEP_OFS_LAT_HIGH 12'hFE1
`define IEP_OFS_LAT_EXT 12'hFE2
`define IEP_OFS_LAT_TOP 12'hFE3
`define IEP_OFS_LVL_A 12'hFF0
`define IEP_OFS_LVL_B 12'hFF1
`define IEP_OFS_LVL_C 12'hFF2

// Reset values
`define IEP_RST_BYTE 8'h00
`define IEP_RST_SRC 22'h000000
`define IEP_RST_LVL 2'h0

// Source numbering
`define IEP_SRC_FIRST 4
`define IEP_SRC_LAST 25
`define IEP_LVL_LAST 15
`define IEP_GIE_BIT 0
`define IEP_WDT_BIT 3

// Identities reported for the non-maskable sources (values arbitrary)
`define IEP_ID_WDT 5'h03
`define IEP_ID_UNDEF 5'h02
`define IEP_ID_SW 5'h01
`define IEP_ID_NONE 5'h00

// Controller registers on the AXI4-Lite side (byte addresses)
`define IEP_AXI_CMD 8'h00
`define IEP_AXI_STAT 8'h04
`define IEP_AXI_RESP_OK 2'h0
`define IEP_AXI_RESP_ERR 2'h2

// Command word fields
`define IEP_CMD_ADDR_HI 11
`define IEP_CMD_DATA_LO 12
`define IEP_CMD_DATA_HI 19
`define IEP_CMD_WR 20
`define IEP_CMD_RD 21
`define IEP_CMD_ACK 22
`define IEP_CMD_RET 23

// Status word fields
`define IEP_ST_REQ 8
`define IEP_ST_SRC_LO 9
`define IEP_ST_SRC_HI 13
`define IEP_ST_NMI 14
`define IEP_ST_GIE 15
`define IEP_ST_REFUSED 16
`define IEP_ST_BUSY 17

// Depth of the saved enable stack
`define IEP_STACK_DEPTH 8
`define IEP_SP_W 3

`endif

// File: src/iep_pkg.sv
// Types shared by both ends of the interrupt enable block
package iep_pkg;
   typedef logic [1:0] iep_level_t;
   typedef logic [4:0] iep_src_t;
   typedef enum logic [1:0] {IEP_IDLE, IEP_READ, IEP_CAPTURE} iep_state_e;
endpackage

// File: src/iep_if.sv
// Special-function register and accept link between the core side and the enable block
`timescale 1ns/1ps
`default_nettype none
interface iep_if;
   logic [11:0] sfr_addr;   // Register address
   logic [7:0] sfr_wdata;   // Write data
   logic sfr_we;            // One-cycle write strobe
   logic sfr_re;            // One-cycle read strobe
   logic [7:0] sfr_rdata;   // Read data, valid the cycle after sfr_re
   logic req_valid;         // An interrupt is offered to the core
   logic [4:0] req_src;     // Number of the offered source
   logic req_nmi;           // Offered source is non-maskable
   logic accept;            // Core takes the offered interrupt
   logic gie;               // Present global enable
   logic ret;               // Return from handler
   logic ret_gie;           // Global enable value to restore
   modport dev (input sfr_addr, sfr_wdata, sfr_we, sfr_re, accept, ret, ret_gie,
                output sfr_rdata, req_valid, req_src, req_nmi, gie);
   modport ctl (output sfr_addr, sfr_wdata, sfr_we, sfr_re, accept, ret, ret_gie,
                input sfr_rdata, req_valid, req_src, req_nmi, gie);
endinterface
`default_nettype wire

// File: src/iep_device.sv
// Interrupt enable, request latch and priority-level logic of the core
`include "iep_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iep_device
   import iep_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic [25:4] I_SRC_REQ,
   input wire logic I_NMI_SW,
   input wire logic I_NMI_UNDEF,
   input wire logic I_NMI_WDT,
   output logic O_GIE,
   iep_if.dev bus
);

   // Stored state
   logic gie_r;                          // Global enable
   logic gie_nxt;
   logic [25:4] en_r;                    // Per-source enables
   logic [25:4] en_nxt;
   logic [25:4] lat_r;                   // Request latches
   logic [25:4] lat_nxt;
   iep_level_t lvl_r [4:15];             // Level fields of sources 4 to 15
   logic [7:0] rdata_r;                  // Registered read data
   logic req_valid_r;                    // Offered request, registered
   iep_src_t req_src_r;
   logic req_nmi_r;

   // Write decode
   wire wr_en_low = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_EN_LOW);
   wire wr_en_high = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_EN_HIGH);
   wire wr_en_ext = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_EN_EXT);
   wire wr_en_top = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_EN_TOP);
   wire wr_lat_low = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LAT_LOW);
   wire wr_lat_high = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LAT_HIGH);
   wire wr_lat_ext = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LAT_EXT);
   wire wr_lat_top = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LAT_TOP);
   wire wr_lvl_a = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LVL_A);
   wire wr_lvl_b = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LVL_B);
   wire wr_lvl_c = bus.sfr_we && (bus.sfr_addr == `IEP_OFS_LVL_C);

   // Accept of a maskable source clears its own latch
   wire acc_mask = bus.accept && req_valid_r && !req_nmi_r;

   // Candidates: latched and individually enabled
   wire [25:4] cand = lat_r & en_r;
   // Any non-maskable request bypasses every enable bit
   wire nmi_any = I_NMI_SW || I_NMI_UNDEF || I_NMI_WDT;

   // Latch clear mask: a written 0 clears, a written 1 leaves the latch alone
   logic [25:4] clr_mask;
   always_comb begin
      clr_mask = `IEP_RST_SRC;
      if (wr_lat_low) begin
         clr_mask[7:4] = ~bus.sfr_wdata[7:4];
      end
      if (wr_lat_high) begin
         clr_mask[15:8] = ~bus.sfr_wdata;
      end
      if (wr_lat_ext) begin
         clr_mask[23:16] = ~bus.sfr_wdata;
      end
      if (wr_lat_top) begin
         clr_mask[25:24] = ~bus.sfr_wdata[1:0];
      end
      if (acc_mask) begin
         clr_mask[req_src_r] = 1'b1;
      end
   end

   // New requests win over a clear in the same cycle, so no event is lost
   assign lat_nxt = (lat_r & ~clr_mask) | I_SRC_REQ;

   // Enable next value; bits beyond source 25 are not stored at all
   always_comb begin
      en_nxt = en_r;
      if (wr_en_low) begin
         en_nxt[7:4] = bus.sfr_wdata[7:4];
      end
      if (wr_en_high) begin
         en_nxt[15:8] = bus.sfr_wdata;
      end
      if (wr_en_ext) begin
         en_nxt[23:16] = bus.sfr_wdata;
      end
      if (wr_en_top) begin
         en_nxt[25:24] = bus.sfr_wdata[1:0];
      end
   end

   // Global enable: accept beats return, return beats a register write
   always_comb begin
      gie_nxt = gie_r;
      if (bus.accept && req_valid_r) begin
         gie_nxt = 1'b0;
      end else if (bus.ret) begin
         gie_nxt = bus.ret_gie;
      end else if (wr_en_low) begin
         gie_nxt = bus.sfr_wdata[`IEP_GIE_BIT];
      end
   end

   // Level of any source; sources above 15 have no field here and sit at 0
   function automatic iep_level_t level_of(input int src);
      level_of = `IEP_RST_LVL;
      if (src <= `IEP_LVL_LAST) begin
         level_of = lvl_r[src];
      end
   endfunction

   // Arbitration among candidates: larger level wins, on a tie the lower
   // source number (higher fixed priority) wins. The scan runs downward and
   // replaces on equal level so that the lowest number is kept at the end.
   logic win_any;
   iep_src_t win_src;
   iep_level_t win_lvl;
   always_comb begin
      win_any = 1'b0;
      win_src = `IEP_ID_NONE;
      win_lvl = `IEP_RST_LVL;
      for (int s = `IEP_SRC_LAST; s >= `IEP_SRC_FIRST; s--) begin
         if (cand[s] && (!win_any || level_of(s) >= win_lvl)) begin
            win_any = 1'b1;
            win_src = iep_src_t'(s);
            win_lvl = level_of(s);
         end
      end
   end

   // Offered request: non-maskable first, maskable only with global enable
   wire offer_valid = nmi_any || (gie_r && win_any);
   wire [4:0] nmi_src = I_NMI_WDT ? `IEP_ID_WDT :
                        I_NMI_UNDEF ? `IEP_ID_UNDEF : `IEP_ID_SW;
   wire [4:0] offer_src = nmi_any ? nmi_src : win_src;

   // Packed views of the level fields; the highest source sits on bits 7:6
   wire [7:0] lvl_a_rd = {lvl_r[7], lvl_r[6], lvl_r[5], lvl_r[4]};
   wire [7:0] lvl_b_rd = {lvl_r[11], lvl_r[10], lvl_r[9], lvl_r[8]};
   wire [7:0] lvl_c_rd = {lvl_r[15], lvl_r[14], lvl_r[13], lvl_r[12]};

   // Read multiplexer; unused and unmapped bits return zero
   logic [7:0] rd_mux;
   always_comb begin
      case (bus.sfr_addr)
         `IEP_OFS_EN_LOW: rd_mux = {en_r[7:4], 3'h0, gie_r};
         `IEP_OFS_EN_HIGH: rd_mux = en_r[15:8];
         `IEP_OFS_EN_EXT: rd_mux = en_r[23:16];
         `IEP_OFS_EN_TOP: rd_mux = {6'h00, en_r[25:24]};
         `IEP_OFS_LAT_LOW: rd_mux = {lat_r[7:4], I_NMI_WDT, 3'h0};
         `IEP_OFS_LAT_HIGH: rd_mux = lat_r[15:8];
         `IEP_OFS_LAT_EXT: rd_mux = lat_r[23:16];
         `IEP_OFS_LAT_TOP: rd_mux = {6'h00, lat_r[25:24]};
         `IEP_OFS_LVL_A: rd_mux = lvl_a_rd;
         `IEP_OFS_LVL_B: rd_mux = lvl_b_rd;
         `IEP_OFS_LVL_C: rd_mux = lvl_c_rd;
         default: rd_mux = `IEP_RST_BYTE;
      endcase
   end

   // Enables, global enable and latches
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         gie_r <= 1'b0;
         en_r <= `IEP_RST_SRC;
         lat_r <= `IEP_RST_SRC;
      end else begin
         gie_r <= gie_nxt;
         en_r <= en_nxt;
         lat_r <= lat_nxt;
      end
   end

   // Level fields: each 2-bit field holds its level number as written
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         for (int s = `IEP_SRC_FIRST; s <= `IEP_LVL_LAST; s++) begin
            lvl_r[s] <= `IEP_RST_LVL;
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (wr_lvl_a) begin
               lvl_r[4 + k] <= bus.sfr_wdata[2 * k +: 2];
            end
            if (wr_lvl_b) begin
               lvl_r[8 + k] <= bus.sfr_wdata[2 * k +: 2];
            end
            if (wr_lvl_c) begin
               lvl_r[12 + k] <= bus.sfr_wdata[2 * k +: 2];
            end
         end
      end
   end

   // Read data and the offered request, all from flip-flops
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rdata_r <= `IEP_RST_BYTE;
         req_valid_r <= 1'b0;
         req_src_r <= `IEP_ID_NONE;
         req_nmi_r <= 1'b0;
      end else begin
         if (bus.sfr_re) begin
            rdata_r <= rd_mux;
         end
         req_valid_r <= offer_valid;
         req_src_r <= offer_src;
         req_nmi_r <= nmi_any;
      end
   end

   // The offer lags state by one cycle; the core must not accept twice in a row
   assign bus.sfr_rdata = rdata_r;
   assign bus.req_valid = req_valid_r;
   assign bus.req_src = req_src_r;
   assign bus.req_nmi = req_nmi_r;
   assign bus.gie = gie_r;
   assign O_GIE = gie_r;

endmodule
`default_nettype wire

// File: src/iep_ctrl.sv
// Core-side controller: turns AXI4-Lite commands into register accesses and accepts
`include "iep_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iep_ctrl
   import iep_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   iep_if.ctl bus
);

   // AXI write and read side
   logic aw_got_r;
   logic [7:0] aw_addr_r;
   logic w_got_r;
   logic [31:0] w_data_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   // Command and status state
   iep_state_e st_r;
   logic [7:0] rd_byte_r;
   logic refused_r;
   logic [31:0] pulse_r;                 // Command driving the link this cycle
   logic pulse_v_r;
   logic stack_r [0:`IEP_STACK_DEPTH-1]; // Saved global enables
   logic [`IEP_SP_W-1:0] sp_r;

   assign O_AWREADY = !aw_got_r && !bvalid_r;
   assign O_WREADY = !w_got_r && !bvalid_r;
   assign O_ARREADY = !rvalid_r;
   wire do_write = aw_got_r && w_got_r && !bvalid_r;
   // A command word counts only when one of its operation bits is set
   wire cmd_hit = do_write && (aw_addr_r == `IEP_AXI_CMD)
                  && w_data_r[`IEP_CMD_RET:`IEP_CMD_WR] != 4'h0;
   wire stat_hit = do_write && (aw_addr_r == `IEP_AXI_STAT);
   wire wr_map = (aw_addr_r == `IEP_AXI_CMD) || (aw_addr_r == `IEP_AXI_STAT);

   // Refusals protect the device: no setting of global and source enables
   // together, and no enable or level change while the global enable is on, except a low enable write that clears it
   wire [11:0] c_addr = w_data_r[`IEP_CMD_ADDR_HI:0];
   wire [7:0] c_data = w_data_r[`IEP_CMD_DATA_HI:`IEP_CMD_DATA_LO];
   wire c_wr = w_data_r[`IEP_CMD_WR];
   wire to_en = c_addr >= `IEP_OFS_EN_LOW && c_addr <= `IEP_OFS_EN_TOP;
   wire to_lvl = c_addr >= `IEP_OFS_LVL_A && c_addr <= `IEP_OFS_LVL_C;
   wire both_set = c_addr == `IEP_OFS_EN_LOW && c_data[`IEP_GIE_BIT] && |c_data[7:4];
   wire hi_set = c_addr == `IEP_OFS_EN_HIGH && bus.gie && |c_data;
   // Clearing the global enable is always let through, else it could never be switched off
   wire gie_off = c_addr == `IEP_OFS_EN_LOW && !c_data[`IEP_GIE_BIT];
   wire gie_busy = bus.gie && (to_en || to_lvl) && !both_set && !gie_off;
   wire bad_ack = w_data_r[`IEP_CMD_ACK] && !bus.req_valid;
   wire bad_ret = w_data_r[`IEP_CMD_RET] && sp_r == '0;
   wire refuse = (c_wr && (both_set || hi_set || gie_busy)) || bad_ack || bad_ret
                 || st_r != IEP_IDLE;
   wire issue = cmd_hit && !refuse;

   // Link strobes come from the registered command for one cycle
   assign bus.sfr_addr = pulse_r[`IEP_CMD_ADDR_HI:0];
   assign bus.sfr_wdata = pulse_r[`IEP_CMD_DATA_HI:`IEP_CMD_DATA_LO];
   assign bus.sfr_we = pulse_v_r && pulse_r[`IEP_CMD_WR];
   assign bus.sfr_re = pulse_v_r && pulse_r[`IEP_CMD_RD];
   assign bus.accept = pulse_v_r && pulse_r[`IEP_CMD_ACK];
   assign bus.ret = pulse_v_r && pulse_r[`IEP_CMD_RET];
   assign bus.ret_gie = stack_r[sp_r - 1'b1];

   // AXI write channel capture and response
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         aw_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_got_r <= 1'b0;
         w_data_r <= 32'h00000000;
         bvalid_r <= 1'b0;
         bresp_r <= `IEP_AXI_RESP_OK;
      end else begin
         if (I_AWVALID && O_AWREADY) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= I_AWADDR;
         end
         if (I_WVALID && O_WREADY) begin
            w_got_r <= 1'b1;
            w_data_r <= I_WDATA;
         end
         if (do_write) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? `IEP_AXI_RESP_OK : `IEP_AXI_RESP_ERR;
         end else if (bvalid_r && I_BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // AXI read channel: status word, unmapped answers with an error
   wire [31:0] stat_word = {14'h0000, st_r != IEP_IDLE, refused_r, bus.gie, bus.req_nmi,
                            bus.req_src, bus.req_valid, rd_byte_r};
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `IEP_AXI_RESP_OK;
      end else if (I_ARVALID && O_ARREADY) begin
         rvalid_r <= 1'b1;
         rdata_r <= (I_ARADDR == `IEP_AXI_STAT) ? stat_word : 32'h00000000;
         rresp_r <= (I_ARADDR == `IEP_AXI_STAT || I_ARADDR == `IEP_AXI_CMD) ?
                    `IEP_AXI_RESP_OK : `IEP_AXI_RESP_ERR;
      end else if (rvalid_r && I_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   // Command sequencer: a read waits one cycle for the registered data
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_r <= IEP_IDLE;
         pulse_r <= 32'h00000000;
         pulse_v_r <= 1'b0;
         rd_byte_r <= 8'h00;
         refused_r <= 1'b0;
      end else begin
         pulse_v_r <= issue;
         if (issue) begin
            pulse_r <= w_data_r;
         end
         // A new refusal wins over a clear in the same cycle
         if (cmd_hit && refuse) begin
            refused_r <= 1'b1;
         end else if (stat_hit && w_data_r[`IEP_ST_REFUSED]) begin
            refused_r <= 1'b0;
         end
         case (st_r)
            IEP_IDLE: begin
               if (issue && w_data_r[`IEP_CMD_RD]) begin
                  st_r <= IEP_READ;
               end
            end
            IEP_READ: begin
               st_r <= IEP_CAPTURE;
            end
            IEP_CAPTURE: begin
               rd_byte_r <= bus.sfr_rdata;
               st_r <= IEP_IDLE;
            end
            default: begin
               st_r <= IEP_IDLE;
            end
         endcase
      end
   end

   // Enable stack: push on accept, pop on return; at sp_r 7 a push writes slot 7, which no return reads
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sp_r <= '0;
         for (int i = 0; i < `IEP_STACK_DEPTH; i++) begin
            stack_r[i] <= 1'b0;
         end
      end else if (bus.accept) begin
         stack_r[sp_r] <= bus.gie;
         sp_r <= (sp_r == `IEP_SP_W'(`IEP_STACK_DEPTH - 1)) ? sp_r : sp_r + 1'b1;
      end else if (bus.ret) begin
         sp_r <= sp_r - 1'b1;
      end
   end

   assign O_BVALID = bvalid_r;
   assign O_BRESP = bresp_r;
   assign O_RVALID = rvalid_r;
   assign O_RDATA = rdata_r;
   assign O_RRESP = rresp_r;

   // Byte strobes are accepted but ignored: every command is one whole word
   wire unused_ok = &{1'b0, I_WSTRB};

endmodule
`default_nettype wire

// File: verif/iep_link_monitor.sv
// Checker on the link between the core-side controller and the enable block
`timescale 1ns/1ps
`default_nettype none
module iep_link_monitor (
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic [11:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_we,
   input wire logic sfr_re,
   input wire logic [7:0] sfr_rdata,
   input wire logic req_valid,
   input wire logic [4:0] req_src,
   input wire logic req_nmi,
   input wire logic accept,
   input wire logic gie,
   input wire logic ret,
   input wire logic ret_gie
);
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_B);
   // Write aimed at the low enable register, which holds the global bit
   wire lo_we = sfr_we && (sfr_addr == 12'h03A);
   // Accept with an offer up outranks every other gie source; the check expects it to win on every accept
   a_accept_clears_gie: assert property (accept |=> !gie)
      else $error("global enable kept after accept");
   a_ret_restores_gie: assert property (ret && !accept |=> gie == $past(ret_gie))
      else $error("return did not restore global enable");
   a_gie_write_lands: assert property (lo_we && !accept && !ret |=> gie == $past(sfr_wdata[0]))
      else $error("global enable differs from written bit");
   a_gie_holds_still: assert property (!accept && !ret && !lo_we |=> $stable(gie))
      else $error("global enable moved without cause");
   a_low_ro_zero: assert property (sfr_re && sfr_addr == 12'h03A |=> sfr_rdata[3:1] == 3'h0)
      else $error("low enable bits 3 to 1 not zero");
   a_top_unused_zero: assert property (sfr_re && sfr_addr == 12'h03D |=> sfr_rdata[7:2] == 6'h00)
      else $error("unused top enable bits not zero");
   // Offer is registered one cycle behind the state, hence the look back
   a_mask_needs_gie: assert property (req_valid && !req_nmi |-> $past(gie))
      else $error("maskable offer while global enable clear");
   a_src_in_range: assert property (req_valid && !req_nmi |-> req_src >= 5'h04 && req_src <= 5'h19)
      else $error("maskable offer outside sources 4 to 25");
   a_nmi_ident: assert property (req_nmi |-> req_valid && req_src inside {5'h01, 5'h02, 5'h03})
      else $error("non-maskable offer with bad identity");
   // Main scenarios reached
   c_accept: cover property (accept);
   c_ret: cover property (ret);
   c_nmi: cover property (req_nmi);
   c_mask: cover property (req_valid && !req_nmi);
endmodule
`default_nettype wire

// File: verif/iep_bench.sv
// Self-checking bench: AXI4-Lite master driving controller and enable block
`timescale 1ns/1ps
`default_nettype none
module iep_bench;
   logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, gie_o;
   logic [7:0] awaddr, araddr, b;
   logic [31:0] wdata, rdata, s;
   logic [1:0] bresp, rresp, r;
   logic [25:4] src;   // Maskable request lines
   logic [2:0] nmi;    // Software, undefined, watchdog
   logic [11:0] regs [7] = '{12'h03A, 12'h03B, 12'h03C, 12'h03D, 12'hFF0, 12'hFF1, 12'hFF2};
   int bad_count, cmp_count;
   iep_if lnk();
   iep_device i_iep_device (.I_MCLK(clk), .I_RST_B(rst_b), .I_SRC_REQ(src), .I_NMI_SW(nmi[0]),
      .I_NMI_UNDEF(nmi[1]), .I_NMI_WDT(nmi[2]), .O_GIE(gie_o), .bus(lnk));
   // Write strobes are ignored by the controller, so they stay all ones
   iep_ctrl i_iep_ctrl (.I_MCLK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .bus(lnk));
   iep_link_monitor i_iep_link_monitor (.I_MCLK(clk), .I_RST_B(rst_b),
      .sfr_addr(lnk.sfr_addr), .sfr_wdata(lnk.sfr_wdata), .sfr_we(lnk.sfr_we),
      .sfr_re(lnk.sfr_re), .sfr_rdata(lnk.sfr_rdata), .req_valid(lnk.req_valid),
      .req_src(lnk.req_src), .req_nmi(lnk.req_nmi), .accept(lnk.accept), .gie(lnk.gie),
      .ret(lnk.ret), .ret_gie(lnk.ret_gie));
   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Verdict and end of run
   task automatic wrap_up;
      $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // A wait that ran out counts as a mismatch and ends the run
   task automatic limit(input int n);
      if (n >= 50) begin
         bad_count++;
         wrap_up();
      end
   endtask
   // AXI write: AW and W offered together, each dropped when taken, bready up until bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      bit ap, wp, got;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ap = 1;
      wp = 1;
      got = 0;
      n = 0;
      while (!got && n < 50) begin
         @(posedge clk);
         n++;
         if (bvalid) begin
            got = 1;
            rs = bresp;
         end
         if (ap && awready) begin
            ap = 0;
            awvalid <= 1'b0;
         end
         if (wp && wready) begin
            wp = 0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
      limit(n);
   endtask
   // AXI read: rready held from the start until rvalid is sampled
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      bit ap, got;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ap = 1;
      got = 0;
      n = 0;
      while (!got && n < 50) begin
         @(posedge clk);
         n++;
         if (!ap && rvalid) begin
            got = 1;
            d = rdata;
            rs = rresp;
         end
         if (ap && arready) begin
            ap = 0;
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
      limit(n);
   endtask
   // Command word, then poll status until the link is idle again
   task automatic cmd(input logic [23:0] w);
      int n;
      axi_wr(8'h00, {8'h00, w}, r);
      chk(r, 2'h0);
      n = 0;
      do begin
         axi_rd(8'h04, s, r);
         n++;
      end while (s[17] && n < 50);
      limit(n);
   endtask
   task automatic sfr_wr(input logic [11:0] a, input logic [7:0] d);
      cmd({4'b0001, d, a});
   endtask
   task automatic sfr_rd(input logic [11:0] a, output logic [7:0] d);
      cmd({4'b0010, 8'h00, a});
      d = s[7:0];
   endtask
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, nmi, src} = '0;
      {awaddr, araddr, wdata, bad_count, cmp_count} = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // Every enable and level register starts cleared
      foreach (regs[i]) begin
         sfr_rd(regs[i], b);
         chk(b, 8'h00);
      end
      $display("reset values done");
      // Read-only and unused bits read zero; writable bits hold
      sfr_wr(12'h03A, 8'hFE);
      sfr_rd(12'h03A, b);
      chk(b, 8'hF0);
      for (int i = 1; i < 4; i++) begin
         sfr_wr(regs[i], 8'hFF);
         sfr_rd(regs[i], b);
         chk(b, (i == 3) ? 8'h03 : 8'hFF);
      end
      for (int i = 4; i < 7; i++) begin
         sfr_wr(regs[i], 8'hA5);
         sfr_rd(regs[i], b);
         chk(b, 8'hA5);
      end
      foreach (regs[i]) sfr_wr(regs[i], 8'h00);
      $display("access kinds done");
      // Global and low source enables set together are refused
      sfr_wr(12'h03A, 8'hF1);
      chk(s[16], 1'b1);
      sfr_rd(12'h03A, b);
      chk(b, 8'h00);
      axi_wr(8'h04, 32'h0001_0000, r);
      axi_rd(8'h08, s, r);
      chk(s, 32'h0);
      chk(r, 2'h2);
      axi_wr(8'h08, 32'h0, r);
      chk(r, 2'h2);
      $display("refusals done");
      // Latched source offered only with its enable and the global enable
      sfr_wr(12'h03B, 8'h02);
      @(posedge clk) src[9] <= 1'b1;
      @(posedge clk) src[9] <= 1'b0;
      sfr_wr(12'hFE1, 8'hFF);
      sfr_rd(12'hFE1, b);
      chk(b, 8'h02);
      chk(s[8], 1'b0);
      sfr_wr(12'h03A, 8'h01);
      chk(s[15:8], {1'b1, 1'b0, 5'd9, 1'b1});
      chk(gie_o, 1'b1);
      cmd({4'b0100, 8'h00, 12'h001});
      chk(s[15], 1'b0);
      sfr_rd(12'hFE1, b);
      chk(b, 8'h00);
      cmd({4'b1000, 8'h00, 12'h001});
      chk(s[15], 1'b1);
      sfr_wr(12'h03A, 8'h00);
      chk(s[15], 1'b0);
      $display("masking done");
      // Levels against basic priority; source 10 latched but never enabled
      sfr_wr(12'h03B, 8'h09);
      @(posedge clk) src <= 22'h000D0;
      @(posedge clk) src <= '0;
      for (int lv = 0; lv < 4; lv++) begin
         sfr_wr(12'hFF1, {lv[1:0], 4'b1100, 2'b01});
         sfr_rd(12'hFF1, b);
         chk(b, {lv[1:0], 6'b110001});
         sfr_wr(12'h03A, 8'h01);
         chk(s[13:8], {(lv > 1) ? 5'd11 : 5'd8, 1'b1});
         sfr_wr(12'h03A, 8'h00);
      end
      sfr_wr(12'hFE1, 8'h00);
      sfr_wr(12'h03B, 8'h00);
      $display("priority done");
      // Non-maskable sources pass with every enable clear
      for (int k = 0; k < 3; k++) begin
         @(posedge clk) nmi[k] <= 1'b1;
         repeat (3) @(posedge clk);
         axi_rd(8'h04, s, r);
         chk(s[14:8], {1'b1, k[4:0] + 5'd1, 1'b1});
         @(posedge clk) nmi[k] <= 1'b0;
         repeat (3) @(posedge clk);
      end
      // Clear the sticky refusal first so that only this accept can set it
      axi_wr(8'h04, 32'h0001_0000, r);
      cmd({4'b0100, 8'h00, 12'h001});
      chk(s[16], 1'b1);
      $display("non-maskable done");
      wrap_up();
   end
endmodule
`default_nettype wire
